// ---- inc/lamp_brightness_regs.vh ----
// Constants for the lamp brightness control block
`ifndef LAMP_BRIGHTNESS_REGS_VH
`define LAMP_BRIGHTNESS_REGS_VH

// ****************************************
// Register bus map (byte addresses)
// ****************************************
`define REG_CTRL 5'h00
`define REG_STATUS 5'h04
`define REG_LATCH0 5'h08
`define REG_LATCH1 5'h0C
`define REG_COUNTER 5'h10
`define CTRL_RESET 1'h0
`define CTRL_SERIAL_BIT 0

// ****************************************
// Status field positions
// ****************************************
`define ST_SWITCH_BIT 5
`define ST_SS_HOLD_BIT 6
`define ST_SHUTDOWN_BIT 7
`define ST_OPEN_LAMP_BIT 8
`define ST_BANK_BIT 9
`define ST_LAMP_HOLD_BIT 10

// ****************************************
// Configuration byte and latches
// ****************************************
`define BANK_TARGET_BIT 7
`define FULL_OFF_BIT 6
`define LAMP_HOLD_BIT 5
`define LATCH0_RESET 7'h10
`define LATCH1_RESET 7'h50
`define COUNT_PRESET 5'h10
`define COUNT_MAX 5'h1F
`define COUNT_MIN 5'h00
`define SMB_DEVICE_ADDR 7'h2D

// ****************************************
// Switching timing
// ****************************************
`define CLK_FREQ_KHZ 10000
`define FREQ_SLOW_KHZ 145
`define FREQ_FAST_KHZ 290
`define PERIOD_SLOW_CYC (`CLK_FREQ_KHZ / `FREQ_SLOW_KHZ)
`define PERIOD_FAST_CYC (`CLK_FREQ_KHZ / `FREQ_FAST_KHZ)

`endif

// ---- src/lamp_brightness_control.v ----
// Lamp brightness control: step counter, SMBus latches, switch gating
//
// Local design decisions: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "lamp_brightness_regs.vh"

// Contract
// - Open-lamp sense high forces switch off
// - Switch on each cycle, off at current limit
// - Soft-start held low in reset or lamp off
// - Released soft-start ramps by constant current
// - Soft-start fifth limit also ends on-time
// - Sync level selects 145 or 290 kHz
// - Sync rising edge restarts cycle, switch on
// - Counter presets 10000 at reset, both high
// - Increment rising edge adds one
// - Decrement rising edge subtracts one
// - Counter saturates, never wraps
// - Low-power pin off keeps count, resumes
// - Shutdown keeps state, accepts inputs
// - One SMBus byte sets whole configuration
// - Two 7-bit latches, selected one drives
// - Respond only to address 0101101
// - Bank pin chooses active latch
// - Bit 7 routes byte to latch
// - Bits 4..0 brightness, latch0 starts 10000
// - Hold bit stops lamp, off bit shuts down
module lamp_brightness_control (
  input wire clk,
  input wire rstn,
  input wire [4:0] address,
  input wire read,
  input wire write,
  input wire [31:0] writedata,
  output reg [31:0] readdata,
  output reg waitrequest,
  input wire stepUpIn,
  input wire stepDownIn,
  input wire lowPowerSelectN,
  input wire latchBankSelect,
  input wire syncIn,
  input wire syncAtRef,
  input wire openLampHigh,
  input wire currentTrip,
  input wire softStartTrip,
  input wire smbClk,
  input wire smbDataIn,
  output reg smbDataOut,
  output wire smbDataOe,
  output reg powerSwitchOn,
  output reg softStartHold,
  output reg analogEnable,
  output reg [4:0] brightnessCode
);
  // ****************************************
  // Pin synchronisation
  // ****************************************
  localparam PIN_COUNT = 11;
  localparam P_UP = 0;
  localparam P_DOWN = 1;
  localparam P_LOWPWR = 2;
  localparam P_BANK = 3;
  localparam P_SYNC = 4;
  localparam P_SYNC_REF = 5;
  localparam P_OPEN = 6;
  localparam P_ITRIP = 7;
  localparam P_SSTRIP = 8;
  localparam P_SCL = 9;
  localparam P_SDA = 10;
  localparam integer PERIOD_SLOW_INT = `PERIOD_SLOW_CYC;
  localparam integer PERIOD_FAST_INT = `PERIOD_FAST_CYC;
  localparam [31:0] PERIOD_SLOW_WIDE = PERIOD_SLOW_INT;
  localparam [31:0] PERIOD_FAST_WIDE = PERIOD_FAST_INT;
  localparam [7:0] PERIOD_SLOW = PERIOD_SLOW_WIDE[7:0];
  localparam [7:0] PERIOD_FAST = PERIOD_FAST_WIDE[7:0];

  wire [PIN_COUNT-1:0] pinLevel;
  wire [PIN_COUNT-1:0] pinRise;

  pin_sync #(
    .WIDTH(PIN_COUNT)
  ) u_pin_sync (
    .clk(clk),
    .rstn(rstn),
    .pinIn({smbDataIn, smbClk, softStartTrip, currentTrip, openLampHigh, syncAtRef,
            syncIn, latchBankSelect, lowPowerSelectN, stepDownIn, stepUpIn}),
    .level(pinLevel),
    .rise(pinRise)
  );

  // ****************************************
  // SMBus receiver
  // ****************************************
  wire smbStrobe;
  wire [7:0] smbByte;

  smb_byte_slave u_smb (
    .clk(clk),
    .rstn(rstn),
    .sclLevel(pinLevel[P_SCL]),
    .sdaLevel(pinLevel[P_SDA]),
    .sdaOe(smbDataOe),
    .byteStrobe(smbStrobe),
    .byteData(smbByte)
  );

  // ****************************************
  // Configuration state
  // ****************************************
  reg serialMode;
  reg [4:0] stepCount;
  reg [6:0] latch0;
  reg [6:0] latch1;
  reg [7:0] cycleCount;
  reg [4:0] next_brightness;
  reg next_shutdown;
  reg next_lampHold;
  reg [6:0] activeLatch;
  reg lampOff;
  wire [7:0] period;
  wire cycleEnd;
  wire busAccept;
  reg next_switch;
  reg cycleRestart;
  reg [31:0] statusWord;
  reg [31:0] next_readdata;

  // Selected latch drives the lamp in serial mode
  always @* begin
    activeLatch = pinLevel[P_BANK] ? latch1 : latch0;
    if (serialMode) begin
      next_brightness = activeLatch[4:0];
      next_shutdown = ~activeLatch[`FULL_OFF_BIT];
      next_lampHold = ~activeLatch[`LAMP_HOLD_BIT];
    end else begin
      next_brightness = stepCount;
      next_shutdown = ~pinLevel[P_LOWPWR];
      next_lampHold = 1'b0;
    end
    lampOff = (next_brightness == 5'h00) | next_shutdown | next_lampHold;
  end

  // Step counter keeps its value through shutdown
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      stepCount <= `COUNT_PRESET;
    end else if (pinLevel[P_UP] && pinLevel[P_DOWN]) begin
      stepCount <= `COUNT_PRESET;
    end else if (pinRise[P_UP] && !pinRise[P_DOWN]) begin
      if (stepCount != `COUNT_MAX) begin
        stepCount <= stepCount + 5'h01;
      end
    end else if (pinRise[P_DOWN] && !pinRise[P_UP]) begin
      if (stepCount != `COUNT_MIN) begin
        stepCount <= stepCount - 5'h01;
      end
    end
  end

  // Latches load in any mode, including shutdown
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      latch0 <= `LATCH0_RESET;
      latch1 <= `LATCH1_RESET;
    end else if (smbStrobe) begin
      if (smbByte[`BANK_TARGET_BIT]) begin
        latch1 <= smbByte[6:0];
      end else begin
        latch0 <= smbByte[6:0];
      end
    end
  end

  // ****************************************
  // Switching cycle and switch gating
  // ****************************************
  assign period = pinLevel[P_SYNC_REF] ? PERIOD_FAST : PERIOD_SLOW;
  assign cycleEnd = (cycleCount >= period - 8'h01);

  // Gating priority: faults, sync restart, trips, cycle start
  always @* begin
    cycleRestart = pinRise[P_SYNC] | cycleEnd;
    next_switch = powerSwitchOn;
    if (pinLevel[P_OPEN] || lampOff) begin
      next_switch = 1'b0;
    end else if (pinRise[P_SYNC]) begin
      next_switch = 1'b1;
    end else if (pinLevel[P_ITRIP] || pinLevel[P_SSTRIP]) begin
      // Trip still high at a period-end cycle start keeps switch off
      next_switch = 1'b0;
    end else if (cycleEnd) begin
      next_switch = 1'b1;
    end
  end

  // ****************************************
  // Lamp drive outputs
  // ****************************************

  // Outputs follow the active configuration
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      softStartHold <= 1'b1;
      analogEnable <= 1'b0;
      brightnessCode <= `COUNT_PRESET;
    end else begin
      brightnessCode <= next_brightness;
      analogEnable <= ~next_shutdown;
      softStartHold <= lampOff;
    end
  end

  // Cycle counter restarts on sync rise or period end
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cycleCount <= 8'h00;
    end else if (cycleRestart) begin
      cycleCount <= 8'h00;
    end else begin
      cycleCount <= cycleCount + 8'h01;
    end
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      powerSwitchOn <= 1'b0;
    end else begin
      powerSwitchOn <= next_switch;
    end
  end

  // ****************************************
  // Register bus slave
  // ****************************************
  assign busAccept = (read || write) && waitrequest;

  // Status word and read data of the addressed register
  always @* begin
    statusWord = 32'h00000000;
    statusWord[4:0] = brightnessCode;
    statusWord[`ST_SWITCH_BIT] = powerSwitchOn;
    statusWord[`ST_SS_HOLD_BIT] = softStartHold;
    statusWord[`ST_SHUTDOWN_BIT] = next_shutdown;
    statusWord[`ST_OPEN_LAMP_BIT] = pinLevel[P_OPEN];
    statusWord[`ST_BANK_BIT] = pinLevel[P_BANK];
    statusWord[`ST_LAMP_HOLD_BIT] = next_lampHold;
    case (address)
      `REG_CTRL: begin
        next_readdata = {31'h00000000, serialMode};
      end
      `REG_STATUS: begin
        next_readdata = statusWord;
      end
      `REG_LATCH0: begin
        next_readdata = {25'h0000000, latch0};
      end
      `REG_LATCH1: begin
        next_readdata = {25'h0000000, latch1};
      end
      `REG_COUNTER: begin
        next_readdata = {27'h0000000, stepCount};
      end
      default: begin
        next_readdata = 32'h00000000;
      end
    endcase
  end

  // Control register is the only writable location
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      serialMode <= `CTRL_RESET;
    end else if (write && !waitrequest && address == `REG_CTRL) begin
      serialMode <= writedata[`CTRL_SERIAL_BIT];
    end
  end

  // One wait cycle per request, then one answer cycle
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      waitrequest <= 1'b1;
      readdata <= 32'h00000000;
    end else begin
      waitrequest <= ~busAccept;
      if (busAccept && read) begin
        readdata <= next_readdata;
      end
    end
  end

  // Data line is only ever pulled low, never driven high
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      smbDataOut <= 1'b0;
    end else begin
      smbDataOut <= 1'b0;
    end
  end
endmodule // lamp_brightness_control

// ---- src/pin_sync.v ----
// Three-stage pin synchroniser with agreement filter and rise pulses
`timescale 1ns/1ps
module pin_sync #(
  parameter WIDTH = 1
) (
  input wire clk,
  input wire rstn,
  input wire [WIDTH-1:0] pinIn,
  output reg [WIDTH-1:0] level,
  output reg [WIDTH-1:0] rise
);
  reg [WIDTH-1:0] stage1;
  reg [WIDTH-1:0] stage2;
  reg [WIDTH-1:0] stage3;
  wire [WIDTH-1:0] agree;
  wire [WIDTH-1:0] next_level;

  // Level moves only where stages two and three agree
  assign agree = ~(stage2 ^ stage3);
  assign next_level = (stage2 & agree) | (level & ~agree);

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      stage1 <= {WIDTH{1'b0}};
      stage2 <= {WIDTH{1'b0}};
      stage3 <= {WIDTH{1'b0}};
      level <= {WIDTH{1'b0}};
      rise <= {WIDTH{1'b0}};
    end else begin
      stage1 <= pinIn;
      stage2 <= stage1;
      stage3 <= stage2;
      level <= next_level;
      rise <= next_level & ~level;
    end
  end
endmodule // pin_sync

// ---- src/smb_byte_slave.v ----
// SMBus single-byte write receiver with fixed address
`timescale 1ns/1ps
`include "lamp_brightness_regs.vh"
module smb_byte_slave (
  input wire clk,
  input wire rstn,
  input wire sclLevel,
  input wire sdaLevel,
  output reg sdaOe,
  output reg byteStrobe,
  output reg [7:0] byteData
);
  localparam ST_IDLE = 3'd0;
  localparam ST_ADDR = 3'd1;
  localparam ST_ACK_ADDR = 3'd2;
  localparam ST_DATA = 3'd3;
  localparam ST_ACK_DATA = 3'd4;
  localparam ST_IGNORE = 3'd5;

  reg [2:0] state;
  reg [3:0] bitCnt;
  reg [7:0] shiftReg;
  reg sclPrev;
  reg sdaPrev;
  wire sclRise;
  wire sclFall;
  wire startSeen;
  wire stopSeen;

  assign sclRise = sclLevel & ~sclPrev;
  assign sclFall = ~sclLevel & sclPrev;
  assign startSeen = sclLevel & sclPrev & sdaPrev & ~sdaLevel;
  assign stopSeen = sclLevel & sclPrev & ~sdaPrev & sdaLevel;

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state <= ST_IDLE;
      bitCnt <= 4'h0;
      shiftReg <= 8'h00;
      sclPrev <= 1'b1;
      sdaPrev <= 1'b1;
      sdaOe <= 1'b0;
      byteStrobe <= 1'b0;
      byteData <= 8'h00;
    end else begin
      sclPrev <= sclLevel;
      sdaPrev <= sdaLevel;
      byteStrobe <= 1'b0;
      if (startSeen) begin
        state <= ST_ADDR;
        bitCnt <= 4'h0;
        sdaOe <= 1'b0;
      end else if (stopSeen) begin
        state <= ST_IDLE;
        sdaOe <= 1'b0;
      end else begin
        case (state)
          ST_ADDR, ST_DATA: begin
            if (sclRise && bitCnt != 4'h8) begin
              shiftReg <= {shiftReg[6:0], sdaLevel};
              bitCnt <= bitCnt + 4'h1;
            end else if (sclFall && bitCnt == 4'h8) begin
              bitCnt <= 4'h0;
              if (state == ST_ADDR) begin
                // Acknowledge only our own address with a write
                if (shiftReg[7:1] == `SMB_DEVICE_ADDR && !shiftReg[0]) begin
                  state <= ST_ACK_ADDR;
                  sdaOe <= 1'b1;
                end else begin
                  state <= ST_IGNORE;
                end
              end else begin
                // Data byte complete: hand it over and start the acknowledge in the same cycle
                state <= ST_ACK_DATA;
                sdaOe <= 1'b1;
                byteStrobe <= 1'b1;
                byteData <= shiftReg;
              end
            end
          end
          ST_ACK_ADDR: begin
            if (sclFall) begin
              sdaOe <= 1'b0;
              state <= ST_DATA;
            end
          end
          ST_ACK_DATA: begin
            if (sclFall) begin
              sdaOe <= 1'b0;
              state <= ST_IGNORE;
            end
          end
          ST_IGNORE, ST_IDLE: begin
            sdaOe <= 1'b0;
          end
          default: begin
            state <= ST_IDLE;
            sdaOe <= 1'b0;
          end
        endcase
      end
    end
  end
endmodule // smb_byte_slave

// ---- testbench/lamp_brightness_control_chk.sv ----
// Port assertions for the lamp brightness control block
`timescale 1ns/1ps
module lamp_brightness_control_chk (
  input wire clk,
  input wire rstn,
  input wire [4:0] address,
  input wire read,
  input wire [31:0] readdata,
  input wire waitrequest,
  input wire openLampHigh,
  input wire currentTrip,
  input wire softStartTrip,
  input wire syncIn,
  input wire powerSwitchOn,
  input wire softStartHold,
  input wire analogEnable,
  input wire [4:0] brightnessCode
);
  // ****************
  // Assertions
  // ****************
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  property p_open; openLampHigh [*8] |-> !powerSwitchOn; endproperty
  a_open: assert property (p_open) else $error("switch on, open lamp");
  property p_trip; (currentTrip && !syncIn) [*8] |-> !powerSwitchOn; endproperty
  a_trip: assert property (p_trip) else $error("switch on past limit");
  property p_ssTrip; (softStartTrip && !syncIn) [*8] |-> !powerSwitchOn; endproperty
  a_ssTrip: assert property (p_ssTrip) else $error("switch on past soft limit");
  property p_zero; (brightnessCode == 5'h00) [*2] |-> softStartHold; endproperty
  a_zero: assert property (p_zero) else $error("soft start free at code 0");
  property p_off; !analogEnable [*2] |-> softStartHold; endproperty
  a_off: assert property (p_off) else $error("soft start free in shutdown");
  property p_hold; softStartHold [*2] |-> !powerSwitchOn; endproperty
  a_hold: assert property (p_hold) else $error("switch on while held");
  property p_ack; !waitrequest |=> waitrequest; endproperty
  a_ack: assert property (p_ack) else $error("wait low too long");
  property p_unmap; read && !waitrequest && address > 5'h10 |-> readdata == 32'h0; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
endmodule // lamp_brightness_control_chk
bind lamp_brightness_control lamp_brightness_control_chk u_chk (
  .clk(clk), .rstn(rstn), .address(address), .read(read), .readdata(readdata),
  .waitrequest(waitrequest), .openLampHigh(openLampHigh), .currentTrip(currentTrip),
  .softStartTrip(softStartTrip), .syncIn(syncIn), .powerSwitchOn(powerSwitchOn), .softStartHold(softStartHold),
  .analogEnable(analogEnable), .brightnessCode(brightnessCode)
);

// ---- testbench/smb_host_model.sv ----
// SMBus host model issuing single-byte writes
`timescale 1ns/1ps
module smb_host_model (
  output reg scl,
  output reg sdaPull,
  input wire sda
);
  initial begin
    scl = 1'b1;
    sdaPull = 1'b0;
  end
  task automatic byte_out(input [7:0] v, output ack);
    for (int i = 7; i >= 0; i--) begin
      sdaPull = !v[i];
      #250 scl = 1'b1;
      #300 scl = 1'b0;
      #250;
    end
    sdaPull = 1'b0;
    #250 scl = 1'b1;
    #150 ack = (sda === 1'b0);
    #150 scl = 1'b0;
    #250;
  endtask
  // ****************
  // Start, address, data, stop
  // ****************
  task automatic write_byte(input [6:0] a, input [7:0] d, output ackAddr, output ackData);
    #37 sdaPull = 1'b1;
    #300 scl = 1'b0;
    #250;
    byte_out({a, 1'b0}, ackAddr);
    ackData = 1'b0;
    if (ackAddr) begin
      byte_out(d, ackData);
    end
    sdaPull = 1'b1;
    #250 scl = 1'b1;
    #250 sdaPull = 1'b0;
    #500;
  endtask
endmodule // smb_host_model

// ---- testbench/testbench.sv ----
// Self-checking testbench for the lamp brightness control block
`timescale 1ns/1ps
`include "lamp_brightness_regs.vh"
module testbench;
  reg clk, rstn, read, write, stepUpIn, stepDownIn, lowPowerSelectN, latchBankSelect;
  reg syncIn, syncAtRef, openLampHigh, currentTrip, softStartTrip;
  reg [4:0] address;
  reg [31:0] writedata;
  wire [31:0] readdata;
  wire [4:0] brightnessCode;
  wire waitrequest, smbDataOut, smbDataOe, powerSwitchOn, softStartHold, analogEnable, scl, sdaPull;
  wire sda = !(sdaPull | (smbDataOe & !smbDataOut));
  logic [31:0] expQ[$], mskQ[$];
  logic [7:0] d;
  logic ackAddr, ackData;
  int num_errors, n_tests, seed, k, n;
  lamp_brightness_control u_lamp_brightness_control (
    .clk(clk), .rstn(rstn), .address(address), .read(read), .write(write), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest), .stepUpIn(stepUpIn), .stepDownIn(stepDownIn),
    .lowPowerSelectN(lowPowerSelectN), .latchBankSelect(latchBankSelect), .syncIn(syncIn),
    .syncAtRef(syncAtRef), .openLampHigh(openLampHigh), .currentTrip(currentTrip),
    .softStartTrip(softStartTrip), .smbClk(scl), .smbDataIn(sda), .smbDataOut(smbDataOut),
    .smbDataOe(smbDataOe), .powerSwitchOn(powerSwitchOn), .softStartHold(softStartHold),
    .analogEnable(analogEnable), .brightnessCode(brightnessCode)
  );
  smb_host_model u_smb_host_model (.scl(scl), .sdaPull(sdaPull), .sda(sda));
  initial begin
    clk = 1'b0;
    forever #50 clk = !clk;
  end
  // ****************
  // Tasks
  // ****************
  task automatic check(input [31:0] got, input [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input [4:0] a, input wr, input [31:0] v);
    n = 0;
    @(posedge clk);
    address <= a;
    read <= !wr;
    write <= wr;
    writedata <= v;
    @(posedge clk);
    while (waitrequest !== 1'b0 && n < 20) begin
      n++;
      @(posedge clk);
    end
    if (n == 20) begin
      num_errors++;
      finish_test;
    end
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input [4:0] a, input [31:0] exp, input [31:0] msk);
    expQ.push_back(exp);
    mskQ.push_back(msk);
    bus(a, 1'b0, 32'h0);
  endtask
  task automatic pulse(input up, input dn);
    stepUpIn <= up;
    stepDownIn <= dn;
    repeat (5) @(posedge clk);
    stepUpIn <= 1'b0;
    stepDownIn <= 1'b0;
    repeat (5) @(posedge clk);
  endtask
  task automatic finish_test;
    $display("mismatches %0d of %0d checks", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    if (read === 1'b1 && waitrequest === 1'b0) begin
      check(readdata & mskQ.pop_front(), expQ.pop_front());
    end
  end
  initial begin
    #1000000;
    num_errors++;
    finish_test;
  end
  // ****************
  // Scenarios
  // ****************
  initial begin
    {rstn, read, write, stepUpIn, stepDownIn, lowPowerSelectN, latchBankSelect} = 7'h00;
    {syncIn, syncAtRef, openLampHigh, currentTrip, softStartTrip} = 5'h00;
    address = 5'h00;
    writedata = 32'h0;
    seed = 32'h1B2C;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rd(`REG_LATCH0, 32'h10, 32'hFFFFFFFF);
    rd(`REG_LATCH1, 32'h50, 32'hFFFFFFFF);
    rd(`REG_COUNTER, 32'h10, 32'hFFFFFFFF);
    rd(5'h14, 32'h0, 32'hFFFFFFFF);
    $display("test reset done");
    lowPowerSelectN <= 1'b1;
    repeat (18) pulse(1'b1, 1'b0);
    rd(`REG_STATUS, 32'h1F, 32'h1F);
    repeat (34) pulse(1'b0, 1'b1);
    rd(`REG_COUNTER, 32'h0, 32'hFFFFFFFF);
    rd(`REG_STATUS, 32'h40, 32'h60);
    pulse(1'b1, 1'b1);
    rd(`REG_COUNTER, 32'h10, 32'hFFFFFFFF);
    k = {$random(seed)} % 8;
    repeat (k) pulse(1'b1, 1'b0);
    rd(`REG_COUNTER, 32'h10 + k, 32'hFFFFFFFF);
    lowPowerSelectN <= 1'b0;
    pulse(1'b0, 1'b1);
    rd(`REG_STATUS, 32'h8F + k, 32'h9F);
    lowPowerSelectN <= 1'b1;
    repeat (8) @(posedge clk);
    rd(`REG_STATUS, 32'h0, 32'h80);
    $display("test counter done");
    syncAtRef <= $random(seed);
    repeat (40) @(posedge clk);
    syncIn <= 1'b1;
    repeat (6) @(posedge clk);
    syncIn <= 1'b0;
    openLampHigh <= 1'b1;
    repeat (10) @(posedge clk);
    rd(`REG_STATUS, 32'h100, 32'h160);
    openLampHigh <= 1'b0;
    currentTrip <= 1'b1;
    repeat (10) @(posedge clk);
    rd(`REG_STATUS, 32'h0, 32'h20);
    currentTrip <= 1'b0;
    softStartTrip <= 1'b1;
    repeat (10) @(posedge clk);
    rd(`REG_STATUS, 32'h0, 32'h20);
    softStartTrip <= 1'b0;
    n = 0;
    while (powerSwitchOn !== 1'b1 && n < 80) begin
      n++;
      @(posedge clk);
    end
    check({31'h0, powerSwitchOn}, 32'h1);
    $display("test switch done");
    bus(`REG_CTRL, 1'b1, 32'h1);
    u_smb_host_model.write_byte(`SMB_DEVICE_ADDR, 8'hEA, ackAddr, ackData);
    check({31'h0, ackAddr}, 32'h1);
    check({31'h0, ackData}, 32'h1);
    rd(`REG_LATCH1, 32'h6A, 32'hFFFFFFFF);
    rd(`REG_STATUS, 32'h90, 32'h9F);
    latchBankSelect <= 1'b1;
    repeat (8) @(posedge clk);
    rd(`REG_STATUS, 32'h0A, 32'hDF);
    u_smb_host_model.write_byte(7'h2C, 8'h7F, ackAddr, ackData);
    check({31'h0, ackAddr}, 32'h0);
    rd(`REG_LATCH0, 32'h10, 32'hFFFFFFFF);
    d = 8'h40 | 8'($random(seed) & 32'h1F);
    u_smb_host_model.write_byte(`SMB_DEVICE_ADDR, d, ackAddr, ackData);
    rd(`REG_LATCH0, {24'h0, d}, 32'hFFFFFFFF);
    latchBankSelect <= 1'b0;
    repeat (8) @(posedge clk);
    rd(`REG_STATUS, 32'h40, 32'hC0);
    $display("test serial done");
    finish_test;
  end
endmodule // testbench
